// ===== design/rsb_cfg.svh
// Register offsets, field positions, reset values and timing counts of the stage
`ifndef RSB_CFG_SVH
`define RSB_CFG_SVH

// ==========================================
// Register byte offsets
`define RSB_OFS_CTRL      8'h00
`define RSB_OFS_PICKUP    8'h04
`define RSB_OFS_DELAY     8'h08
`define RSB_OFS_MAXRATE   8'h0C
`define RSB_OFS_STATUS    8'h10
`define RSB_OFS_RATIO     8'h14
`define RSB_OFS_TREMAIN   8'h18
`define RSB_OFS_TEXPECT   8'h1C
`define RSB_OFS_CNT_START 8'h20
`define RSB_OFS_CNT_TRIP  8'h24
`define RSB_OFS_CNT_BLOCK 8'h28
`define RSB_OFS_REC_SEL   8'h2C
`define RSB_OFS_REC_TLO   8'h30
`define RSB_OFS_REC_THI   8'h34
`define RSB_OFS_REC_INFO  8'h38
`define RSB_OFS_REC_PRE   8'h3C
`define RSB_OFS_REC_FLT   8'h40
`define RSB_OFS_REC_CNT   8'h44

// ==========================================
// Control register fields
`define RSB_CTRL_ENABLE   0
`define RSB_CTRL_MODE_LO  1
`define RSB_CTRL_MODE_HI  2
`define RSB_CTRL_LN_LO    3
`define RSB_CTRL_LN_HI    5
`define RSB_CTRL_CNT_CLR  6
`define RSB_CTRL_EVM_LO   8
`define RSB_CTRL_EVM_HI   13

// ==========================================
// Reset values
`define RSB_RST_CTRL      32'h0000_3F00
`define RSB_RST_PICKUP    16'h00C8
`define RSB_RST_DELAY     19'h0_0014
`define RSB_RST_MAXRATE   16'h4E20

// ==========================================
// Timing and scaling
`define RSB_CLK_PERIOD_NS 8
`define RSB_PROC_CYCLE_NS 5000000
`define RSB_PRETRIG_MS    20
`define RSB_PROC_CYCLE_MS 5
`define RSB_HYST_MHZS     16'h0064
`define RSB_RATIO_SCALE   8'hC8
`define RSB_RATIO_MAX     16'h0FA0
`define RSB_REC_DEPTH     12

`endif

// ===== design/rsb_event_counter.sv
// Resettable 32-bit cumulative occurrence counter
`timescale 1ns/1ps
module rsb_event_counter (
    // Clock and control
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Count and clear
    input  wire logic        i_inc,
    input  wire logic        i_clr,
    // Value
    output logic [31:0]      o_count
);

    // Occurrence in the clearing cycle is kept
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_count <= 32'h0000_0000;
        end else if (i_ce) begin
            if (i_clr) begin
                o_count <= {31'h0000_0000, i_inc};
            end else if (i_inc) begin
                o_count <= o_count + 32'h0000_0001;
            end
        end
    end

endmodule

// ===== design/rsb_pkg.sv
// Types shared by the stage logic
package rsb_pkg;

    typedef enum logic [1:0] {
        RSB_NORMAL  = 2'b00,
        RSB_START   = 2'b01,
        RSB_TRIP    = 2'b10,
        RSB_BLOCKED = 2'b11
    } rsb_cond_type;

    typedef enum logic [1:0] {
        RSB_RISING  = 2'b00,
        RSB_FALLING = 2'b01,
        RSB_BOTH    = 2'b10
    } rsb_dir_type;

    typedef enum logic [2:0] {
        RSB_LN_ON      = 3'b000,
        RSB_LN_BLOCKED = 3'b001,
        RSB_LN_TEST    = 3'b010,
        RSB_LN_TESTBLK = 3'b011,
        RSB_LN_OFF     = 3'b100
    } rsb_ln_type;

    typedef enum logic [2:0] {
        RSB_EV_START_ON  = 3'b000,
        RSB_EV_START_OFF = 3'b001,
        RSB_EV_TRIP_ON   = 3'b010,
        RSB_EV_TRIP_OFF  = 3'b011,
        RSB_EV_BLK_ON    = 3'b100,
        RSB_EV_BLK_OFF   = 3'b101
    } rsb_event_type;

endpackage

// ===== design/rsb_record_ring.sv
// Ring of the twelve most recent time-stamped operation records
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_record_ring (
    // Clock and control
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // New record
    input  wire logic         i_wr,
    input  wire logic [119:0] i_rec,
    // Readout, index 0 is newest
    input  wire logic [3:0]   i_sel,
    output logic [119:0]      o_rec,
    output logic [3:0]        o_count
);

    logic [119:0] mem [0:`RSB_REC_DEPTH-1];
    logic [3:0]   wr_ptr;
    logic [3:0]   rd_idx;

    // Oldest slot is overwritten once full
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr  <= 4'h0;
            o_count <= 4'h0;
        end else if (i_ce && i_wr) begin
            wr_ptr <= (wr_ptr == 4'(`RSB_REC_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1; // R11
            if (o_count != 4'(`RSB_REC_DEPTH)) begin
                o_count <= o_count + 4'h1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_ce && i_wr) begin
            mem[wr_ptr] <= i_rec; // R11
        end
    end

    always_comb begin
        if (i_sel >= o_count) begin
            rd_idx = 4'h0;
        end else if (wr_ptr > i_sel) begin
            rd_idx = wr_ptr - i_sel - 4'h1;
        end else begin
            rd_idx = 4'(`RSB_REC_DEPTH) + wr_ptr - i_sel - 4'h1;
        end
    end

    assign o_rec = (i_sel < o_count) ? mem[rd_idx] : 120'h0;

endmodule

// ===== design/rsb_top.sv
// Rate-of-change-of-frequency stage: blocking, fixed delay, events, counters, records
// How it works
// R1 - The operate delay is a fixed count of processing cycles only.
// R2 - Blocking input is sampled at each processing tick before pick-up is judged.
// R3 - Pick-up without blocking raises start and begins the delay count.
// R4 - Pick-up with blocking raises blocked only; no start, timing or trip.
// R5 - Blocking during start clears start and releases as on pick-up drop.
// R6 - Blocking source must assert at least 5 ms before delay expiry.
// R7 - A mask selects which on and off events reach the event buffer.
// R8 - Every emitted event carries the current time stamp.
// R9 - Start, trip and blocked counters are kept and clearable by software.
// R10 - Six events: start, trip and blocked, each on and off.
// R11 - Twelve newest operation records kept, oldest overwritten.
// R12 - Record holds time, event, pre-trigger and fault values, setting group.
// R13 - Condition reads as normal, start, trip or blocked.
// R14 - Measured freq_slope_stage magnitude published in 0.001 Hz/s units.
// R15 - Ratio of freq_slope_stage to pick-up published in 0.005 p.u. steps.
// R16 - Remaining time to trip published signed, in 5 ms steps.
// R17 - Expected operating time published, 0 to 1800 s.
// R18 - Logical-node behaviour reads as on, blocked, test, test/blocked or off.
// R19 - Start, trip and blocked are driven out for I/O and logic; o_trip is held low in test and test/blocked modes.
// R20 - Release needs freq_slope_stage 100 mHz/s below the pick-up value.
// R21 - Direction mode allows rising, falling or both.
// R22 - freq_slope_stage above the maximum allowed rate blocks the stage.
// R23 - Trip on delay expiry while started; trip clears when start releases.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_top #(
    parameter int PROC_CLKS = `RSB_PROC_CYCLE_NS / `RSB_CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    // Avalon-MM slave
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // Measurement and context
    input  wire logic signed [15:0] i_dfdt,
    input  wire logic [15:0]        i_freq,
    input  wire logic               i_block,
    input  wire logic [47:0]        i_time_ms,
    input  wire logic [2:0]         i_setting_group,
    // Stage outputs
    output logic                    o_start,
    output logic                    o_trip,
    output logic                    o_blocked,
    output logic                    o_proc_tick,
    // Event buffer feed
    output logic [5:0]              o_evt,
    output logic [47:0]             o_evt_time
);

    localparam int PRE_DEPTH = `RSB_PRETRIG_MS / `RSB_PROC_CYCLE_MS;

    // ==========================================
    // Registers
    logic [31:0]              ctrl;
    logic [15:0]              pickup;
    logic [18:0]              delay;
    logic [15:0]              maxrate;
    logic [3:0]               rec_sel;
    logic                     ack;
    logic                     wr_hit;
    logic [31:0]              next_rdata;
    logic                     cnt_clr;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_hit          = avs_write & ack;
    assign cnt_clr         = wr_hit && avs_address == `RSB_OFS_CTRL && avs_writedata[`RSB_CTRL_CNT_CLR]; // R9

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
        end else if (i_ce) begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl    <= `RSB_RST_CTRL;
            pickup  <= `RSB_RST_PICKUP;
            delay   <= `RSB_RST_DELAY;
            maxrate <= `RSB_RST_MAXRATE;
            rec_sel <= 4'h0;
        end else if (i_ce && wr_hit) begin
            case (avs_address)
                `RSB_OFS_CTRL:    ctrl    <= avs_writedata & 32'h0000_3F3F;
                `RSB_OFS_PICKUP:  pickup  <= avs_writedata[15:0];
                `RSB_OFS_DELAY:   delay   <= avs_writedata[18:0];
                `RSB_OFS_MAXRATE: maxrate <= avs_writedata[15:0];
                `RSB_OFS_REC_SEL: rec_sel <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Processing tick
    logic [31:0]              tick_cnt;
    logic                     tick;

    assign tick = (tick_cnt == 32'(PROC_CLKS - 1));

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tick_cnt    <= 32'h0000_0000;
            o_proc_tick <= 1'b0;
        end else if (i_ce) begin
            tick_cnt    <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            o_proc_tick <= tick;
        end
    end

    // ==========================================
    // Pick-up element
    rsb_pkg::rsb_ln_type      ln_mode;
    rsb_pkg::rsb_dir_type     dir_mode;
    logic [15:0]              mag;
    logic                     dir_ok;
    logic                     picked;
    logic                     next_picked;
    logic                     enabled;

    assign ln_mode  = rsb_pkg::rsb_ln_type'(ctrl[`RSB_CTRL_LN_HI:`RSB_CTRL_LN_LO]);
    assign dir_mode = rsb_pkg::rsb_dir_type'(ctrl[`RSB_CTRL_MODE_HI:`RSB_CTRL_MODE_LO]);
    assign mag      = i_dfdt[15] ? 16'(-i_dfdt) : 16'(i_dfdt);
    assign enabled  = ctrl[`RSB_CTRL_ENABLE] && ln_mode != rsb_pkg::RSB_LN_OFF;

    always_comb begin
        case (dir_mode)
            rsb_pkg::RSB_RISING:  dir_ok = ~i_dfdt[15]; // R21
            rsb_pkg::RSB_FALLING: dir_ok = i_dfdt[15]; // R21
            default:              dir_ok = 1'b1; // R21
        endcase
        if (picked) begin
            next_picked = dir_ok && {1'b0, mag} + {1'b0, `RSB_HYST_MHZS} >= {1'b0, pickup}; // R20
        end else begin
            next_picked = dir_ok && mag >= pickup;
        end
    end

    // ==========================================
    // Stage state
    rsb_pkg::rsb_cond_type    cond;
    rsb_pkg::rsb_cond_type    next_cond;
    logic [18:0]              op_cnt;
    logic                     blk_now;

    // Blocking taken at the head of the tick
    assign blk_now = i_block | (mag > maxrate) | ln_mode == rsb_pkg::RSB_LN_BLOCKED // R2 R22
                   | ln_mode == rsb_pkg::RSB_LN_TESTBLK;

    always_comb begin
        next_cond = cond;
        case (cond)
            rsb_pkg::RSB_NORMAL: begin
                if (next_picked && blk_now) begin
                    next_cond = rsb_pkg::RSB_BLOCKED; // R4
                end else if (next_picked) begin
                    next_cond = rsb_pkg::RSB_START; // R3
                end
            end
            rsb_pkg::RSB_START: begin
                if (blk_now) begin
                    next_cond = next_picked ? rsb_pkg::RSB_BLOCKED : rsb_pkg::RSB_NORMAL; // R5
                end else if (!next_picked) begin
                    next_cond = rsb_pkg::RSB_NORMAL;
                end else if (op_cnt + 19'h0_0001 >= delay) begin
                    next_cond = rsb_pkg::RSB_TRIP; // R1 R23
                end
            end
            rsb_pkg::RSB_TRIP: begin
                if (blk_now) begin
                    next_cond = next_picked ? rsb_pkg::RSB_BLOCKED : rsb_pkg::RSB_NORMAL; // R5
                end else if (!next_picked) begin
                    next_cond = rsb_pkg::RSB_NORMAL; // R23
                end
            end
            rsb_pkg::RSB_BLOCKED: begin
                if (!next_picked || !blk_now) begin
                    next_cond = rsb_pkg::RSB_NORMAL;
                end
            end
            default: next_cond = rsb_pkg::RSB_NORMAL;
        endcase
        if (!enabled) begin
            next_cond = rsb_pkg::RSB_NORMAL;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cond   <= rsb_pkg::RSB_NORMAL;
            picked <= 1'b0;
        end else if (i_ce && tick) begin
            cond   <= next_cond; // R13
            picked <= next_picked & enabled;
        end
    end

    // Fixed delay count in processing cycles
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            op_cnt <= 19'h0_0000;
        end else if (i_ce && tick) begin
            if (next_cond == rsb_pkg::RSB_START && cond == rsb_pkg::RSB_START) begin
                op_cnt <= op_cnt + 19'h0_0001; // R1
            end else begin
                op_cnt <= 19'h0_0000; // R5
            end
        end
    end

    // ==========================================
    // Outputs and events
    logic                     st_now;
    logic                     tr_now;
    logic                     bl_now;
    logic                     st_prev;
    logic                     tr_prev;
    logic                     bl_prev;
    logic [5:0]               ev_raw;
    logic                     test_mode;

    assign st_now    = cond == rsb_pkg::RSB_START || cond == rsb_pkg::RSB_TRIP;
    assign tr_now    = cond == rsb_pkg::RSB_TRIP;
    assign bl_now    = cond == rsb_pkg::RSB_BLOCKED;
    assign test_mode = ln_mode == rsb_pkg::RSB_LN_TEST || ln_mode == rsb_pkg::RSB_LN_TESTBLK;
    assign ev_raw    = {bl_prev & ~bl_now, bl_now & ~bl_prev, // R10
                        tr_prev & ~tr_now, tr_now & ~tr_prev,
                        st_prev & ~st_now, st_now & ~st_prev};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_prev    <= 1'b0;
            tr_prev    <= 1'b0;
            bl_prev    <= 1'b0;
            o_evt      <= 6'h00;
            o_evt_time <= 48'h0000_0000_0000;
            o_start    <= 1'b0;
            o_trip     <= 1'b0;
            o_blocked  <= 1'b0;
        end else if (i_ce) begin
            st_prev    <= st_now;
            tr_prev    <= tr_now;
            bl_prev    <= bl_now;
            o_evt      <= ev_raw & ctrl[`RSB_CTRL_EVM_HI:`RSB_CTRL_EVM_LO]; // R7
            o_evt_time <= i_time_ms; // R8
            o_start    <= st_now; // R19
            o_trip     <= tr_now & ~test_mode; // R19
            o_blocked  <= bl_now; // R19
        end
    end

    // ==========================================
    // Counters
    logic [31:0]              cnt_start;
    logic [31:0]              cnt_trip;
    logic [31:0]              cnt_block;

    rsb_event_counter u_cnt_start (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_inc   (ev_raw[0]),
        .i_clr   (cnt_clr),
        .o_count (cnt_start)
    ); // R9

    rsb_event_counter u_cnt_trip (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_inc   (ev_raw[2]),
        .i_clr   (cnt_clr),
        .o_count (cnt_trip)
    ); // R9

    rsb_event_counter u_cnt_block (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_inc   (ev_raw[4]),
        .i_clr   (cnt_clr),
        .o_count (cnt_block)
    ); // R9

    // ==========================================
    // Pre-trigger history and records
    logic [31:0]              hist [0:PRE_DEPTH];
    logic [119:0]             rec_in;
    logic [119:0]             rec_out;
    logic [3:0]               rec_cnt;
    logic                     rec_wr;
    rsb_pkg::rsb_event_type   rec_ev;

    always_ff @(posedge i_mclk) begin
        if (i_ce && tick) begin
            hist[0] <= {i_freq, i_dfdt};
            for (int i = 1; i <= PRE_DEPTH; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    assign rec_wr = ev_raw[0] | ev_raw[2];
    assign rec_ev = ev_raw[2] ? rsb_pkg::RSB_EV_TRIP_ON : rsb_pkg::RSB_EV_START_ON;
    // Fault is the tick sample, pre-trigger the one four ticks older
    assign rec_in = {i_time_ms, 1'b0, rec_ev, 1'b0, i_setting_group, // R12
                     hist[PRE_DEPTH], hist[0]};

    rsb_record_ring u_ring (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_wr    (rec_wr),
        .i_rec   (rec_in),
        .i_sel   (rec_sel),
        .o_rec   (rec_out),
        .o_count (rec_cnt)
    ); // R11

    // ==========================================
    // Ratio divider, run once per tick
    logic [23:0]              div_rem;
    logic [23:0]              div_num;
    logic [23:0]              div_q;
    logic [4:0]               div_step;
    logic [15:0]              ratio;
    logic [24:0]              div_trial;

    assign div_trial = {div_rem, div_num[23]} - {9'h000, pickup};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            div_rem  <= 24'h00_0000;
            div_num  <= 24'h00_0000;
            div_q    <= 24'h00_0000;
            div_step <= 5'h00;
            ratio    <= 16'h0000;
        end else if (i_ce) begin
            if (tick) begin
                div_num  <= 24'(mag) * `RSB_RATIO_SCALE; // R15
                div_rem  <= 24'h00_0000;
                div_q    <= 24'h00_0000;
                div_step <= 5'h18;
            end else if (div_step != 5'h00) begin
                div_num  <= {div_num[22:0], 1'b0};
                div_step <= div_step - 5'h01;
                if (!div_trial[24]) begin
                    div_rem <= div_trial[23:0];
                    div_q   <= {div_q[22:0], 1'b1};
                end else begin
                    div_rem <= {div_rem[22:0], div_num[23]};
                    div_q   <= {div_q[22:0], 1'b0};
                end
                if (div_step == 5'h01) begin
                    ratio <= (pickup == 16'h0000 || div_q > 24'h00_07FF) ? `RSB_RATIO_MAX // R15
                           : ((({div_q[14:0], ~div_trial[24]}) > `RSB_RATIO_MAX) ? `RSB_RATIO_MAX
                           : {div_q[14:0], ~div_trial[24]});
                end
            end
        end
    end

    // ==========================================
    // Read mux
    logic [31:0]              tremain;

    assign tremain = (cond == rsb_pkg::RSB_START) ? 32'(delay) - 32'(op_cnt) : 32'h0000_0000; // R16

    always_comb begin
        case (avs_address)
            `RSB_OFS_CTRL:      next_rdata = ctrl;
            `RSB_OFS_PICKUP:    next_rdata = {16'h0000, pickup};
            `RSB_OFS_DELAY:     next_rdata = {13'h0000, delay};
            `RSB_OFS_MAXRATE:   next_rdata = {16'h0000, maxrate};
            `RSB_OFS_STATUS:    next_rdata = {mag, 8'h00, ln_mode, bl_now, tr_now, st_now, cond}; // R13 R14 R18
            `RSB_OFS_RATIO:     next_rdata = {16'h0000, ratio}; // R15
            `RSB_OFS_TREMAIN:   next_rdata = tremain; // R16
            `RSB_OFS_TEXPECT:   next_rdata = {13'h0000, delay}; // R17
            `RSB_OFS_CNT_START: next_rdata = cnt_start;
            `RSB_OFS_CNT_TRIP:  next_rdata = cnt_trip;
            `RSB_OFS_CNT_BLOCK: next_rdata = cnt_block;
            `RSB_OFS_REC_SEL:   next_rdata = {28'h000_0000, rec_sel};
            `RSB_OFS_REC_TLO:   next_rdata = rec_out[103:72];
            `RSB_OFS_REC_THI:   next_rdata = {16'h0000, rec_out[119:104]};
            `RSB_OFS_REC_INFO:  next_rdata = {24'h00_0000, rec_out[71:64]}; // R12
            `RSB_OFS_REC_PRE:   next_rdata = rec_out[63:32];
            `RSB_OFS_REC_FLT:   next_rdata = rec_out[31:0];
            `RSB_OFS_REC_CNT:   next_rdata = {28'h000_0000, rec_cnt};
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (i_ce && avs_read && !ack) begin
            avs_readdata <= next_rdata;
        end
    end

endmodule

// ===== sim/rsb_top_checker.sv
// Port assertions for the stage top
`timescale 1ns/1ps
module rsb_top_checker #(
    parameter int PROC_CLKS = 32
) (
    // Clock and bus
    input wire logic        i_mclk, i_rst_n, avs_read, avs_write, avs_waitrequest,
    // Context and stage outputs
    input wire logic [47:0] i_time_ms,
    input wire logic        o_start, o_trip, o_blocked, o_proc_tick,
    input wire logic [5:0]  o_evt,
    input wire logic [47:0] o_evt_time
);
    // ==========================================
    // Tick spacing
    logic [31:0] gap;
    logic        seen;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b0;
        end else if (o_proc_tick) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b1;
        end else begin
            gap <= gap + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    one_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus wait state wrong");
    tick_period_a: assert property (o_proc_tick && seen |-> gap == PROC_CLKS - 1)
        else $error("tick spacing wrong");
    start_evt_a: assert property (o_evt[0] |-> o_start && !$past(o_start))
        else $error("start on event without start");
    stop_evt_a: assert property (o_evt[1] |-> !o_start && $past(o_start))
        else $error("start off event while started");
    trip_evt_a: assert property (o_evt[2] |-> o_trip && $past(o_start))
        else $error("trip event without start");
    blk_only_a: assert property (o_blocked |-> !o_start && !o_trip)
        else $error("blocked with start or trip");
    blk_evt_a: assert property (o_evt[4] |-> o_blocked && !$past(o_blocked))
        else $error("blocked event wrong");
    evt_stamp_a: assert property (|o_evt |-> o_evt_time == $past(i_time_ms))
        else $error("event stamp wrong");
    trip_clear_a: assert property ($fell(o_start) |-> !o_trip)
        else $error("trip outlived start");
endmodule
bind rsb_top rsb_top_checker #(.PROC_CLKS(PROC_CLKS)) rsb_top_checker_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .i_time_ms(i_time_ms),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_proc_tick(o_proc_tick), .o_evt(o_evt),
    .o_evt_time(o_evt_time));

// ===== sim/rsb_top_test.sv
// Self-checking bench for the stage top
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_top_test;
    localparam int PC = 32;
    logic i_mclk, i_rst_n, i_ce, avs_read, avs_write, avs_waitrequest, i_block;
    logic o_start, o_trip, o_blocked;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic signed [15:0] i_dfdt;
    logic [15:0] i_freq, df;
    logic [47:0] i_time_ms;
    logic [2:0] i_setting_group, g;
    int num_errors, comparisons;
    time t0;
    wire [2:0] st = {o_blocked, o_trip, o_start};
    rsb_top #(.PROC_CLKS(PC)) rsb_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .i_dfdt(i_dfdt), .i_freq(i_freq),
        .i_block(i_block), .i_time_ms(i_time_ms), .i_setting_group(i_setting_group), .o_start(o_start),
        .o_trip(o_trip), .o_blocked(o_blocked), .o_proc_tick(), .o_evt(), .o_evt_time());
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        i_time_ms <= i_time_ms + 48'h0000_0000_0001;
        i_freq    <= 16'($urandom);
    end
    // ==========================================
    // Tasks
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge i_mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) begin
            chk(32'h0000_0000, 32'h0000_0001);
            tally_and_finish;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic wait_on(input int k, input logic v);
        int n;
        n = 0;
        while (st[k] !== v && n < 2000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            chk(32'h0000_0000, 32'h0000_0001);
            tally_and_finish;
        end
    endtask
    task automatic pick(input logic [15:0] v, input logic b);
        @(posedge i_mclk);
        i_dfdt  <= v;
        i_block <= b;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(85));
        {i_rst_n, avs_read, avs_write, i_block, i_dfdt, i_freq, i_time_ms, avs_address, avs_writedata} = '0;
        i_ce = 1'b1;
        i_setting_group = 3'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(`RSB_OFS_CTRL, `RSB_RST_CTRL);
        rd(`RSB_OFS_PICKUP, 32'(`RSB_RST_PICKUP));
        rd(`RSB_OFS_MAXRATE, 32'(`RSB_RST_MAXRATE));
        rd(`RSB_OFS_TEXPECT, 32'(`RSB_RST_DELAY));
        rd(8'hFC, 32'h0000_0000);
        bus(1'b1, `RSB_OFS_DELAY, 32'h0000_0003);
        bus(1'b1, `RSB_OFS_CTRL, 32'h0000_3F03);
        g = 3'($urandom);
        df = 16'(200 * $urandom_range(2, 5));
        @(posedge i_mclk);
        i_setting_group <= g;
        pick(df, 1'b0);
        repeat (3 * PC) @(posedge i_mclk);
        chk(32'(o_start), 32'h0000_0000);
        bus(1'b1, `RSB_OFS_CTRL, 32'h0000_3F01);
        wait_on(0, 1'b1);
        t0 = $time;
        wait_on(1, 1'b1);
        chk(32'(($time - t0) / 8), 32'(3 * PC));
        bus(1'b0, `RSB_OFS_STATUS, 32'h0000_0000);
        chk(32'(q[1:0]), 32'h0000_0002);
        chk(32'(q[31:16]), 32'(df));
        chk(32'(q[7:2]), 32'h0000_0003);
        rd(`RSB_OFS_RATIO, 32'(df));
        pick(16'h0000, 1'b0);
        wait_on(1, 1'b0);
        chk(32'(o_start), 32'h0000_0000);
        pick(df, 1'b0);
        wait_on(0, 1'b1);
        pick(df, 1'b1);
        wait_on(2, 1'b1);
        chk(32'(st), 32'h0000_0004);
        pick(16'h0000, 1'b0);
        wait_on(2, 1'b0);
        rd(`RSB_OFS_CNT_START, 32'h0000_0002);
        rd(`RSB_OFS_CNT_TRIP, 32'h0000_0001);
        rd(`RSB_OFS_CNT_BLOCK, 32'h0000_0001);
        rd(`RSB_OFS_REC_CNT, 32'h0000_0003);
        rd(`RSB_OFS_REC_INFO, 32'(g));
        bus(1'b1, `RSB_OFS_CTRL, 32'h0000_3F41);
        rd(`RSB_OFS_CNT_START, 32'h0000_0000);
        rd(`RSB_OFS_CTRL, 32'h0000_3F01);
        repeat (10) begin
            pick(16'(200 * $urandom_range(2, 5)), 1'b0);
            wait_on(0, 1'b1);
            pick(16'h0000, 1'b0);
            wait_on(0, 1'b0);
        end
        rd(`RSB_OFS_REC_CNT, 32'(`RSB_REC_DEPTH));
        tally_and_finish;
    end
endmodule
